// File: rtl/wca_pkg.sv
// Package for the write checksum checker and alert block
// Assumes one 25 MHz clock shared by controller and device ends
package wca_pkg;
    // Clock period in ns
    localparam int CLK_PERIOD_NS = 40;
    // Lane layout of an x16 device
    localparam int LANE_BITS = 8;
    localparam int LANES = 2;
    localparam int TREE_INPUTS = 36;
    localparam int BEATS = 4;
    localparam int NIBBLE = 4;
    // Checksum polynomial x^8+x^2+x+1
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    // Alert timing in clocks
    localparam logic [3:0] ALERT_LATENCY = 4'h3;
    localparam logic [3:0] ALERT_PULSE_WIDTH = 4'h6;
    localparam int PARITY_LOW_MIN = 45;
    // Mode register five and readout register three field positions
    localparam int MR5_ERR_BIT = 3;
    localparam int MR3_FLAG_BIT = 7;
    localparam logic [1:0] RESET_ERR = 2'h0;
    // Bit-serial checksum step over one tree input bit
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[7] ^ b;
        crc_step = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    endfunction
endpackage

// File: rtl/wca_if.sv
// Interface joining controller end and device end of the write checksum link
// Assumes the testbench resolves the open-drain alert wire from the enables
`timescale 1ns/1ps
interface wca_if;
    // Write burst: four transferred beats, upper byte lane in bits [15:8]
    logic wr_valid;
    logic [15:0] wr_data [4];
    logic [1:0] mask_lane [4];
    logic [15:0] wr_crc;
    logic col_addr_bit_two;
    // Mode register set for the error bit
    logic mrs_clear;
    // Open-drain alert: device drives low, controller pull-up
    logic alert_o;
    logic alert_oe;
    logic alert_in;
    modport dev (input wr_valid, wr_data, mask_lane, wr_crc, col_addr_bit_two, mrs_clear, alert_in,
        output alert_o, alert_oe);
    modport ctl (output wr_valid, wr_data, mask_lane, wr_crc, col_addr_bit_two, mrs_clear,
        input alert_in);
endinterface

// File: rtl/wca_device.sv
// Device end: maps burst-chop-four data to trees, checks, drives alert
// Assumes writes arrive whole in one cycle from the link interface
// Overview of operation
// - Upper lane uses upper byte, ones after
// - Mask lanes feed 32-35 of each tree, else ones
// - Column bit two does not change tree mapping
// - Checksum errors share the open-drain alert
// - Alert low pulse six clocks; failures during the latency wait share one pulse
// - Controller distinguishes by width only
// - Controller tolerates long chained alert lows
// - Alert starts after checksum alert latency
// - Mismatch sets mode register five bit three
// - Error bit mirrored to readout register bit seven
// - Bits stay set until register write clears
// - Controller raises RETRY_REQ on short pulse
// - Controller may correlate failure to rank
// - Error process starts the next edge
// - Pulse ends at release, pull-up restores
// - Column bit two does not pick burst half order
// - Mask lanes feed only when enabled
// - Two identical 36-input trees, one per byte lane
`timescale 1ns/1ps
module wca_device (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Link to controller
    wca_if.dev LINK,
    // Configuration
    input wire logic MASK_OR_INV_EN,
    // Status
    output logic MODE_REG_FIVE_ERR,
    output logic READOUT_REG_THREE_FLAG,
    output logic ERR_EVENT
);
    // Latency sequencer, one-hot
    typedef enum logic [1:0] {
        ALERT_IDLE = 2'b01,
        ALERT_WAIT = 2'b10
    } wca_alert_t;

    typedef struct packed {
        logic err;
        logic flag;
        logic event_pulse;
        wca_alert_t alert;
        logic [3:0] lat_cnt;
        logic [3:0] pw_cnt;
        logic drive;
    } wca_dev_state_t;

    wca_dev_state_t st, next_st;
    logic [wca_pkg::TREE_INPUTS-1:0] tree_in [wca_pkg::LANES];
    logic [1:0] mismatch;
    logic write_bad;

    // Two trees, one per byte lane: map inputs, then fold them
    genvar g, b, t;
    generate
        for (g = 0; g < wca_pkg::LANES; g++) begin : g_tree
            for (b = 0; b < wca_pkg::LANE_BITS; b++) begin : g_bit
                for (t = 0; t < wca_pkg::BEATS; t++) begin : g_beat
                    // Either burst half lands in the same tree positions
                    assign tree_in[g][b*wca_pkg::BEATS+t] =
                        LINK.wr_data[t][g*wca_pkg::LANE_BITS+b];
                end
            end
            for (t = 0; t < wca_pkg::BEATS; t++) begin : g_mask
                // Mask lane inputs or ones
                assign tree_in[g][wca_pkg::TREE_INPUTS-wca_pkg::BEATS+t] =
                    MASK_OR_INV_EN ? LINK.mask_lane[t][g] : 1'b1;
            end
            // Serial fold of the 36 inputs
            always_comb begin
                logic [7:0] c;
                c = wca_pkg::CRC_INIT;
                for (int k = 0; k < wca_pkg::TREE_INPUTS; k++) begin
                    c = wca_pkg::crc_step(c, tree_in[g][k]);
                end
                mismatch[g] = (c != LINK.wr_crc[g*8 +: 8]);
            end
        end
    endgenerate

    // Any lane mismatch on a valid write is one event
    assign write_bad = LINK.wr_valid && (|mismatch);

    // Next state: latency, pulse and sticky bits
    always_comb begin
        next_st = st;
        next_st.event_pulse = 1'b0;
        if (write_bad) begin
            next_st.event_pulse = 1'b1;
        end
        // Pulse countdown first, so a new pulse start below wins
        if (st.drive) begin
            if (st.pw_cnt > 4'h1) begin
                next_st.pw_cnt = st.pw_cnt - 4'h1;
            end else begin
                next_st.drive = 1'b0;
                next_st.pw_cnt = 4'h0;
            end
        end
        // Latency wait; a new failure restarts it
        unique case (st.alert)
            ALERT_IDLE: begin
                if (write_bad) begin
                    next_st.alert = ALERT_WAIT;
                    next_st.lat_cnt = wca_pkg::ALERT_LATENCY;
                end
            end
            ALERT_WAIT: begin
                if (write_bad) begin
                    next_st.lat_cnt = wca_pkg::ALERT_LATENCY;
                end else if (st.lat_cnt > 4'h1) begin
                    next_st.lat_cnt = st.lat_cnt - 4'h1;
                end else begin
                    next_st.alert = ALERT_IDLE;
                    next_st.drive = 1'b1;
                    next_st.pw_cnt = wca_pkg::ALERT_PULSE_WIDTH;
                end
            end
            default: begin
                next_st.alert = ALERT_IDLE;
            end
        endcase
        // Clear first, set wins
        if (LINK.mrs_clear) begin
            next_st.err = 1'b0;
        end
        if (st.event_pulse) begin
            next_st.err = 1'b1;
        end
        next_st.flag = next_st.err;
    end

    // State register
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st <= '0;
            st.alert <= ALERT_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign LINK.alert_o = 1'b0;
    assign LINK.alert_oe = st.drive;
    assign MODE_REG_FIVE_ERR = st.err;
    assign READOUT_REG_THREE_FLAG = st.flag;
    assign ERR_EVENT = st.event_pulse;
endmodule // wca_device

// File: rtl/wca_controller.sv
// Controller end: issues writes, measures alert low time, clears error bit
// Assumes alert_in is resolved by the testbench from the device enable
`timescale 1ns/1ps
module wca_controller (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Link to device
    wca_if.ctl LINK,
    // User write request
    input wire logic WR_REQ,
    input wire logic [63:0] WR_DATA,
    input wire logic [7:0] WR_MASK,
    input wire logic [15:0] WR_CRC,
    input wire logic WR_COL_BIT_TWO,
    input wire logic CLEAR_REQ,
    // Status
    output logic CRC_ALERT_SEEN,
    output logic PARITY_ALERT_SEEN,
    output logic RETRY_REQ
);
    typedef struct packed {
        logic wr_valid;
        logic [63:0] data;
        logic [7:0] mask;
        logic [15:0] crc;
        logic col;
        logic clr;
        logic s1;
        logic s2;
        logic [7:0] low_cnt;
        logic crc_seen;
        logic par_seen;
        logic retry;
    } wca_ctl_state_t;

    wca_ctl_state_t st, next_st;

    // Classify alert lows by width
    always_comb begin
        next_st = st;
        next_st.wr_valid = WR_REQ;
        next_st.data = WR_DATA;
        next_st.mask = WR_MASK;
        next_st.crc = WR_CRC;
        next_st.col = WR_COL_BIT_TWO;
        next_st.clr = CLEAR_REQ;
        next_st.s1 = LINK.alert_in;
        next_st.s2 = st.s1;
        next_st.crc_seen = 1'b0;
        next_st.par_seen = 1'b0;
        next_st.retry = 1'b0;
        if (!st.s2) begin
            if (st.low_cnt != 8'hFF) begin
                next_st.low_cnt = st.low_cnt + 8'h01;
            end
        end else begin
            next_st.low_cnt = 8'h00;
            if (st.low_cnt != 8'h00) begin
                if (st.low_cnt > 8'(wca_pkg::PARITY_LOW_MIN)) begin
                    next_st.par_seen = 1'b1;
                end else begin
                    next_st.crc_seen = 1'b1;
                    next_st.retry = 1'b1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st <= '0;
            st.s1 <= 1'b1;
            st.s2 <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign LINK.wr_valid = st.wr_valid;
    assign LINK.wr_crc = st.crc;
    assign LINK.col_addr_bit_two = st.col;
    assign LINK.mrs_clear = st.clr;
    generate
        for (genvar t = 0; t < wca_pkg::BEATS; t++) begin : g_beat
            assign LINK.wr_data[t] = st.data[t*16 +: 16];
            assign LINK.mask_lane[t] = st.mask[t*2 +: 2];
        end
    endgenerate
    assign CRC_ALERT_SEEN = st.crc_seen;
    assign PARITY_ALERT_SEEN = st.par_seen;
    assign RETRY_REQ = st.retry;
endmodule // wca_controller

// File: verification/wca_chk.sv
// Assertions on the checksum link and the device status outputs
// Assumes it is instantiated beside the link interface in the testbench
`timescale 1ns/1ps
module wca_chk (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Link and device status
    input wire logic wr_valid,
    input wire logic mrs_clear,
    input wire logic alert_o,
    input wire logic alert_oe,
    input wire logic ERR_EVENT,
    input wire logic MODE_REG_FIVE_ERR,
    input wire logic READOUT_REG_THREE_FLAG
);
    // One clock domain
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // Error event, latency and pulse
    event_next_a: assert property (ERR_EVENT |-> $past(wr_valid))
        else $error("error event without a write");
    alert_delay_a: assert property ($rose(alert_oe) |-> $past(ERR_EVENT, 3))
        else $error("alert start off latency");
    pulse_width_a: assert property ($rose(alert_oe) |-> alert_oe [*6] ##1 !alert_oe)
        else $error("alert pulse width wrong");
    drive_low_a: assert property (alert_oe |-> !alert_o)
        else $error("alert driven high");
    // Sticky error bit and mirror
    err_set_a: assert property (ERR_EVENT |=> MODE_REG_FIVE_ERR)
        else $error("error bit not set");
    err_cause_a: assert property ($rose(MODE_REG_FIVE_ERR) |-> $past(ERR_EVENT))
        else $error("error bit set without event");
    err_hold_a: assert property ($fell(MODE_REG_FIVE_ERR) |-> $past(mrs_clear) || $past(mrs_clear, 2))
        else $error("error bit dropped without clear");
    flag_mirror_a: assert property (READOUT_REG_THREE_FLAG == MODE_REG_FIVE_ERR)
        else $error("readout flag not mirroring");
endmodule // wca_chk

// File: verification/wca_test.sv
// Testbench joining controller and device ends over the link
// Assumes 25 MHz clock and a pull-up on the alert wire
`timescale 1ns/1ps
module wca_test;
    // Clock, reset and user side
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic en = 1'b0;
    logic req = 1'b0;
    logic clr = 1'b0;
    logic [63:0] wd = 64'h0;
    logic [7:0] wm = 8'h00;
    logic [15:0] wc = 16'h0000;
    logic err, flag, ev, crc_seen, par_seen, retry;
    logic sticky = 1'b0;
    logic col = 1'b0;
    int fails = 0;
    int checks = 0;
    wca_if bus ();
    // Open-drain wire with pull-up
    assign bus.alert_in = bus.alert_oe ? 1'b0 : 1'b1;
    always #20 CLK = ~CLK;
    wca_device u_wca_device (.CLK(CLK), .RSTN(RSTN), .LINK(bus.dev), .MASK_OR_INV_EN(en),
        .MODE_REG_FIVE_ERR(err), .READOUT_REG_THREE_FLAG(flag), .ERR_EVENT(ev));
    wca_controller u_wca_controller (.CLK(CLK), .RSTN(RSTN), .LINK(bus.ctl), .WR_REQ(req), .WR_DATA(wd),
        .WR_MASK(wm), .WR_CRC(wc), .WR_COL_BIT_TWO(col), .CLEAR_REQ(clr), .CRC_ALERT_SEEN(crc_seen),
        .PARITY_ALERT_SEEN(par_seen), .RETRY_REQ(retry));
    wca_chk u_wca_chk (.CLK(CLK), .RSTN(RSTN), .wr_valid(bus.wr_valid), .mrs_clear(bus.mrs_clear),
        .alert_o(bus.alert_o), .alert_oe(bus.alert_oe), .ERR_EVENT(ev), .MODE_REG_FIVE_ERR(err),
        .READOUT_REG_THREE_FLAG(flag));
    // Expected checksum of one lane: 32 data bits then 4 mask bits
    function automatic logic [7:0] tree(input logic [63:0] d, input logic [7:0] m, input int l, input logic me);
        logic [7:0] c;
        logic b;
        c = 8'hFF;
        for (int k = 0; k < 36; k++) begin
            b = (k < 32) ? d[16 * (k % 4) + 8 * l + k / 4] : (me ? m[2 * (k - 32) + l] : 1'b1);
            c = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One write, then count events, alert low cycles and controller pulses
    task automatic wr(input logic [63:0] d, input logic [7:0] m, input logic de, input logic ce,
        input logic [15:0] flip, input logic bad);
        int n[5];
        n = '{default: 0};
        @(posedge CLK);
        en <= de;
        wd <= d;
        wm <= m;
        wc <= {tree(d, m, 1, ce), tree(d, m, 0, ce)} ^ flip;
        req <= 1'b1;
        @(posedge CLK);
        req <= 1'b0;
        repeat (30) begin
            @(posedge CLK);
            #1;
            n[0] += ev;
            n[1] += !bus.alert_in;
            n[2] += crc_seen;
            n[3] += retry;
            n[4] += par_seen;
        end
        sticky = sticky | bad;
        chk(n[0], bad);
        chk(n[1], bad ? wca_pkg::ALERT_PULSE_WIDTH : 0);
        chk(n[2] + n[3], bad ? 2 : 0);
        chk(n[4], 0);
        chk(err, sticky);
        chk(flag, sticky);
        $display("write test done at %0t", $time);
    endtask
    // Clear the sticky error bit
    task automatic clear();
        @(posedge CLK);
        clr <= 1'b1;
        @(posedge CLK);
        clr <= 1'b0;
        for (int i = 0; i < 8 && flag !== 1'b0; i++) @(posedge CLK);
        sticky = 1'b0;
        chk(err, 0);
        chk(flag, 0);
        $display("clear test done at %0t", $time);
    endtask
    // Verdict
    task automatic test_done();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge CLK);
        RSTN <= 1'b1;
        @(posedge CLK);
        chk(err | flag | bus.alert_oe, 0);
        wr(64'h0123_4567_89AB_CDEF, 8'h00, 1'b0, 1'b0, 16'h0000, 1'b0);
        wr(64'hFEDC_BA98_7654_3210, 8'hA5, 1'b1, 1'b1, 16'h0000, 1'b0);
        wr(64'hFEDC_BA98_7654_3210, 8'hA5, 1'b0, 1'b0, 16'h0000, 1'b0);
        wr(64'h1111_2222_3333_4444, 8'h5A, 1'b0, 1'b1, 16'h0000, 1'b1);
        wr(64'h0F0F_F0F0_5555_AAAA, 8'h00, 1'b0, 1'b0, 16'h0100, 1'b1);
        wr(64'h0F0F_F0F0_5555_AAAA, 8'h00, 1'b0, 1'b0, 16'h0000, 1'b0);
        wr(64'h8000_0000_0000_0001, 8'hFF, 1'b1, 1'b1, 16'h0080, 1'b1);
        clear();
        wr(64'h8000_0000_0000_0001, 8'hFF, 1'b1, 1'b1, 16'h0000, 1'b0);
        @(posedge CLK);
        col <= 1'b1;
        wr(64'h8000_0000_0000_0001, 8'hFF, 1'b1, 1'b1, 16'h0000, 1'b0);
        wr(64'h0123_4567_89AB_CDEF, 8'h3C, 1'b1, 1'b1, 16'h0001, 1'b1);
        test_done();
    end
endmodule // wca_test
